// ### l2_op_engine.sv
// L2 cache op state machine with Avalon-MM register slave
//
// How it works
// [RULE_01] Inhibit pin low at reset allows auto init
// [RULE_02] Auto init also needs hw_init_enable set
// [RULE_03] Auto init waits out the programmed delay
// [RULE_04] Auto init waits for memory self-test done
// [RULE_05] Auto init clears tag array only
// [RULE_06] Auto init completion sets hw_init_done bit
// [RULE_07] Presence bit reads as one
// [RULE_08] Software starts only when running reads zero
// [RULE_09] Kind 1 tag init, kind 2 tag+data
// [RULE_10] Kind 0 flushes the whole cache
// [RULE_11] Kinds 4,5,6 are hit burst operations
// [RULE_12] Writing command 1 starts selected operation
// [RULE_13] Outcome reads 0 running, 1 success
// [RULE_14] Burst start line from range bits 47:6
// [RULE_15] Burst line count from range bits 63:48
// [RULE_16] Software keeps count within cache size
// [RULE_17] Burst walks lines in order from start
// [RULE_18] Coherent requests held off during auto init
// [RULE_19] Software blocks coherent traffic otherwise
// [RULE_20] Only software launches flush and bursts
// [RULE_21] Running bit is 0 idle, 1 busy
// [RULE_22] hw_init_enable is bit 24
// [RULE_23] Other outcome codes report errors
// [RULE_24] Start while running is ignored
// [RULE_25] Running falls as outcome leaves running
`timescale 1ns/1ns
`include "l2_op_params.svh"

module l2_op_engine
  import l2_op_pkg::*;
#(
  parameter int LINE_W = 42,
  parameter logic [LINE_W-1:0] NUM_LINES = 42'h400
)
(
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Avalon-MM slave
  input wire logic [11:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Pins from outside the clock domain
  input wire logic i_auto_init_inhibit_in,
  input wire logic i_self_test_enable,
  input wire logic i_self_test_done,
  // Per-line operation port toward tag and data RAMs
  output logic o_line_req,
  output logic [LINE_W-1:0] o_line_index,
  output logic [2:0] o_line_kind,
  input wire logic i_line_ack,
  input wire logic i_line_err,
  // Coherent request hold-off
  output logic o_coherent_hold
);

  // Pin synchronisers: three flops, filtered once stages two and three agree
  logic [2:0] sync_a, sync_b, sync_c, pin_filt;
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      sync_c <= 3'h0;
      pin_filt <= 3'h0;
    end
    else if (i_ce)
    begin
      sync_a <= {i_self_test_done, i_self_test_enable, i_auto_init_inhibit_in};
      sync_b <= sync_a;
      sync_c <= sync_b;
      for (int k = 0; k < 3; k++)
        if (sync_b[k] == sync_c[k])
          pin_filt[k] <= sync_c[k];
    end
  end

  logic inhibit_filt, st_en_filt, st_done_filt;
  assign inhibit_filt = pin_filt[0];
  assign st_en_filt = pin_filt[1];
  assign st_done_filt = pin_filt[2];

  // Strap capture of the inhibit pin once the synchroniser has filled
  logic [2:0] settle_cnt;
  logic strap_taken, strap_inhibit;
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      settle_cnt <= 3'h0;
      strap_taken <= 1'b0;
      strap_inhibit <= 1'b1;
    end
    else if (i_ce && !strap_taken)
    begin
      settle_cnt <= settle_cnt + 3'h1;
      if (settle_cnt == `SYNC_SETTLE_CYCLES)
      begin
        strap_taken <= 1'b1;
        strap_inhibit <= inhibit_filt; // [RULE_01]
      end
    end
  end

  // Software registers
  logic hw_init_enable;
  logic [15:0] init_delay;
  logic [2:0] op_kind_select;
  logic [63:0] range_reg;
  logic hw_init_done;
  logic op_engine_running;
  op_outcome_t op_outcome;
  eng_state_t state;

  // Bus handshake: one wait cycle, then the access completes
  logic bus_ack;
  logic bus_req;
  assign bus_req = i_read | i_write;
  assign o_waitrequest = bus_req & ~bus_ack;
  logic wr_now, rd_now;
  assign wr_now = i_write & bus_ack;
  assign rd_now = i_read & bus_ack;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      bus_ack <= 1'b0;
    else if (i_ce)
      bus_ack <= bus_req & ~bus_ack;
  end

  // Byte-lane merge of write data into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction

  // Writable view of the config and control register words
  logic [31:0] cfg_word, ctrl_word, ctrl_new, cfg_new;
  assign cfg_word = {7'h0, hw_init_enable, 8'h0, init_delay};
  assign ctrl_word = {`POS_OP_PRESENT == 31, 22'h0, op_outcome,
                      op_engine_running, op_kind_select, 2'h0};
  assign cfg_new = merge(cfg_word, i_writedata, i_byteenable);
  assign ctrl_new = merge(ctrl_word, i_writedata, i_byteenable);

  // Start request from a command write; ignored while busy
  logic start_cmd;
  assign start_cmd = wr_now && (i_address == `OFS_OP_CTRL_LO)
                     && (ctrl_new[`MSB_OP_COMMAND:0] == `CMD_START); // [RULE_12]

  // Configuration registers written by software
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hw_init_enable <= `RST_HW_INIT_ENABLE;
      init_delay <= `RST_INIT_DELAY;
      op_kind_select <= 3'h0;
      range_reg <= 64'h0;
    end
    else if (i_ce && wr_now)
    begin
      case (i_address)
        `OFS_CLUSTER_CFG:
        begin
          hw_init_enable <= cfg_new[`POS_HW_INIT_ENABLE]; // [RULE_22]
          init_delay <= cfg_new[`MSB_INIT_DELAY:0];
        end
        `OFS_OP_CTRL_LO:
          if (!op_engine_running) // [RULE_24]
            op_kind_select <= ctrl_new[`MSB_OP_KIND:`LSB_OP_KIND];
        `OFS_RANGE_LO:
          range_reg[31:0] <= merge(range_reg[31:0], i_writedata,
                                   i_byteenable);
        `OFS_RANGE_HI:
          range_reg[63:32] <= merge(range_reg[63:32], i_writedata,
                                    i_byteenable);
        default:
          range_reg <= range_reg;
      endcase
    end
  end

  // Read data, registered at the edge that ends the wait cycle; unmapped reads zero
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_readdata <= 32'h0;
    else if (i_ce && bus_req && !bus_ack)
    begin
      case (i_address)
        `OFS_CLUSTER_CFG: o_readdata <= cfg_word;
        `OFS_RAM_CFG_LO: o_readdata <= 32'(hw_init_done) << `POS_HW_INIT_DONE;
        `OFS_OP_CTRL_LO: o_readdata <= ctrl_word; // [RULE_07]
        `OFS_RANGE_LO: o_readdata <= range_reg[31:0];
        `OFS_RANGE_HI: o_readdata <= range_reg[63:32];
        default: o_readdata <= 32'h0;
      endcase
    end
  end

  // Range fields as the burst uses them
  logic [LINE_W-1:0] range_start_line;
  logic [15:0] range_line_count;
  assign range_start_line = range_reg[47:`LSB_RANGE_START]; // [RULE_14]
  assign range_line_count = range_reg[63:48]; // [RULE_15]

  // Delay counter from reset until the programmed delay elapses
  logic [15:0] delay_cnt;
  logic delay_done;
  assign delay_done = delay_cnt >= init_delay;
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      delay_cnt <= 16'h0;
    else if (i_ce && !delay_done)
      delay_cnt <= delay_cnt + 16'h1;
  end

  // Auto init may start once every condition holds
  logic auto_go;
  assign auto_go = strap_taken && !strap_inhibit // [RULE_01]
                   && hw_init_enable // [RULE_02]
                   && delay_done // [RULE_03]
                   && (!st_en_filt || st_done_filt); // [RULE_04]

  // Kind decode
  logic kind_ok, kind_burst;
  always_comb
  begin
    kind_ok = 1'b1;
    kind_burst = 1'b0;
    case (op_kind_t'(op_kind_select))
      KIND_FLUSH: kind_burst = 1'b0; // [RULE_10]
      KIND_INIT_TAG: kind_burst = 1'b0; // [RULE_09]
      KIND_INIT_TAG_DATA: kind_burst = 1'b0;
      KIND_HIT_INV, KIND_HIT_WRITEBACK_INVALIDATE, KIND_HIT_WRITEBACK: kind_burst = 1'b1; // [RULE_11]
      default: kind_ok = 1'b0;
    endcase
  end

  // Engine: walks lines one at a time through the RAM port
  logic [LINE_W-1:0] remaining;
  logic auto_active, line_fault;
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= ST_AUTO_WAIT;
      op_engine_running <= 1'b0;
      op_outcome <= OUT_OK;
      auto_active <= 1'b0;
      hw_init_done <= 1'b0;
      line_fault <= 1'b0;
      remaining <= '0;
      o_line_req <= 1'b0;
      o_line_index <= '0;
      o_line_kind <= 3'h0;
    end
    else if (i_ce)
    begin
      case (state)
        ST_AUTO_WAIT:
        begin
          if (strap_taken && (strap_inhibit || !hw_init_enable))
            state <= ST_IDLE; // Manual path: no auto init this reset
          else if (auto_go)
          begin
            state <= ST_RUN;
            auto_active <= 1'b1;
            op_engine_running <= 1'b1;
            op_outcome <= OUT_RUNNING;
            o_line_kind <= KIND_INIT_TAG; // [RULE_05]
            o_line_index <= '0;
            remaining <= NUM_LINES;
            o_line_req <= 1'b1;
          end
        end
        ST_IDLE:
        begin
          if (start_cmd && !kind_ok)
            op_outcome <= OUT_BAD_KIND; // [RULE_23]
          else if (start_cmd && kind_burst && range_line_count == 16'h0)
            op_outcome <= OUT_OK; // Empty burst completes at once
          else if (start_cmd)
          begin
            state <= ST_RUN;
            op_engine_running <= 1'b1; // [RULE_21]
            op_outcome <= OUT_RUNNING; // [RULE_13]
            line_fault <= 1'b0;
            o_line_kind <= op_kind_select;
            o_line_index <= kind_burst ? range_start_line : '0;
            remaining <= kind_burst ? LINE_W'(range_line_count) : NUM_LINES;
            o_line_req <= 1'b1;
          end
        end
        ST_RUN:
        begin
          if (i_line_ack)
          begin
            o_line_index <= o_line_index + LINE_W'(1); // [RULE_17]
            remaining <= remaining - LINE_W'(1);
            if (remaining == LINE_W'(1))
            begin
              state <= ST_IDLE;
              o_line_req <= 1'b0;
              op_engine_running <= 1'b0; // [RULE_25]
              op_outcome <= (line_fault || i_line_err) ?
                            OUT_LINE_ERROR : OUT_OK; // [RULE_23]
              if (auto_active)
                hw_init_done <= 1'b1; // [RULE_06]
              auto_active <= 1'b0;
            end
            else if (i_line_err)
              line_fault <= 1'b1;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Hold coherent traffic only for auto init; software guards the rest
  assign o_coherent_hold = (state == ST_AUTO_WAIT) || auto_active; // [RULE_18]

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence seq_start_idle;
    i_ce && state == ST_IDLE && start_cmd && kind_ok
      && !(kind_burst && range_line_count == 16'h0);
  endsequence

  sequence seq_last_ack;
    i_ce && state == ST_RUN && i_line_ack && remaining == LINE_W'(1);
  endsequence

  AST_START_RUNS: assert property (seq_start_idle |=> // [RULE_12]
    op_engine_running && op_outcome == OUT_RUNNING && o_line_req)
    else $error("start command did not launch the engine");

  AST_RUN_MEANS_ZERO: assert property ( // [RULE_13]
    op_engine_running == (op_outcome == OUT_RUNNING))
    else $error("running bit and outcome disagree");

  AST_FINISH_TOGETHER: assert property (seq_last_ack |=> // [RULE_25]
    !op_engine_running && op_outcome != OUT_RUNNING && state == ST_IDLE)
    else $error("finish did not drop running with outcome");

  AST_BUSY_IGNORES: assert property ( // [RULE_24]
    (i_ce && state == ST_RUN && wr_now && i_address == `OFS_OP_CTRL_LO)
      |=> $stable(op_kind_select) && $stable(o_line_kind))
    else $error("write while running disturbed the operation");

  AST_BURST_START: assert property ( // [RULE_14]
    (seq_start_idle and kind_burst) |=>
      o_line_index == $past(range_start_line)
      && remaining == LINE_W'($past(range_line_count)))
    else $error("burst did not load start line and count");

  AST_LINE_STEP: assert property ( // [RULE_17]
    (i_ce && state == ST_RUN && i_line_ack && remaining != LINE_W'(1))
      |=> o_line_index == $past(o_line_index) + LINE_W'(1)
          && o_line_req)
    else $error("line index did not advance by one");

  AST_AUTO_TAG_ONLY: assert property ( // [RULE_05]
    auto_active |-> o_line_kind == KIND_INIT_TAG)
    else $error("auto init used a kind other than tag-only");

  AST_AUTO_GATED: assert property ( // [RULE_04]
    $rose(auto_active) |->
      !$past(st_en_filt) || $past(st_done_filt))
    else $error("auto init began before self-test finished");

  AST_AUTO_CONDS: assert property ( // [RULE_03]
    $rose(auto_active)
      |-> $past(delay_done) && $past(hw_init_enable)
          && !$past(strap_inhibit) && $past(strap_taken))
    else $error("auto init began before its conditions held");

  AST_DONE_AFTER_AUTO: assert property ( // [RULE_06]
    (seq_last_ack ##0 auto_active) |=> hw_init_done && !o_coherent_hold)
    else $error("init done not set at end of auto init");

  AST_HOLD_AUTO: assert property ( // [RULE_18]
    auto_active |-> o_coherent_hold)
    else $error("coherent requests not held during auto init");

  AST_BUS_ONE_WAIT: assert property (
    ($rose(bus_req) && i_ce) |-> o_waitrequest ##1 !o_waitrequest)
    else $error("bus access not completed after one wait cycle");

endmodule // l2_op_engine

// ### l2_op_params.svh
// Register offsets, field positions, reset values and counts of the L2 op engine
`ifndef L2_OP_PARAMS_SVH
`define L2_OP_PARAMS_SVH

// Byte offsets of the 32-bit bus words (64-bit registers span two words)
`define OFS_CLUSTER_CFG 12'h008
`define OFS_RAM_CFG_LO 12'h240
`define OFS_RAM_CFG_HI 12'h244
`define OFS_OP_CTRL_LO 12'h620
`define OFS_OP_CTRL_HI 12'h624
`define OFS_RANGE_LO 12'h628
`define OFS_RANGE_HI 12'h62c

// cluster_local_status_config fields
`define POS_HW_INIT_ENABLE 24
`define MSB_INIT_DELAY 15
`define RST_HW_INIT_ENABLE 1'h1
`define RST_INIT_DELAY 16'h0010

// l2_ram_configuration field
`define POS_HW_INIT_DONE 16

// l2_op_control_status fields (low word)
`define MSB_OP_COMMAND 1
`define LSB_OP_KIND 2
`define MSB_OP_KIND 4
`define POS_OP_RUNNING 5
`define LSB_OP_OUTCOME 6
`define MSB_OP_OUTCOME 8
`define POS_OP_PRESENT 31
`define CMD_START 2'h1

// l2_op_range_address fields (line index bits 47:6, count bits 63:48)
`define LSB_RANGE_START 6
`define LSB_RANGE_COUNT 16

// Inputs pass this many flops before the strap is taken
`define SYNC_SETTLE_CYCLES 3'h4

`endif

// ### l2_op_pkg.sv
// Types shared by the L2 op engine
package l2_op_pkg;

  // Operation kinds selected by software
  typedef enum logic [2:0] {
    KIND_FLUSH = 3'h0,
    KIND_INIT_TAG = 3'h1,
    KIND_INIT_TAG_DATA = 3'h2,
    KIND_HIT_INV = 3'h4,
    KIND_HIT_WRITEBACK_INVALIDATE = 3'h5,
    KIND_HIT_WRITEBACK = 3'h6
  } op_kind_t;

  // Completion codes
  typedef enum logic [2:0] {
    OUT_RUNNING = 3'h0,
    OUT_OK = 3'h1,
    OUT_LINE_ERROR = 3'h2,
    OUT_BAD_KIND = 3'h3
  } op_outcome_t;

  // Engine states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_AUTO_WAIT = 3'b010,
    ST_RUN = 3'b100
  } eng_state_t;

endpackage

// ### line_ram_model.sv
// Behavioural tag and data RAM side that answers per-line requests
`timescale 1ns/1ns
module line_ram_model
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Line request from the engine
  input wire logic i_line_req,
  input wire logic [41:0] i_line_index,
  // Test controls: answer delay and one faulty line
  input wire logic [3:0] i_delay,
  input wire logic i_err_en,
  input wire logic [41:0] i_err_index,
  // Answer toward the engine
  output logic o_line_ack,
  output logic o_line_err
);
  logic [3:0] wait_cnt;

  // Ack pulse after i_delay cycles; err toggles outside acks so it is
  // never mistaken for a held value
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wait_cnt <= 4'h0;
      o_line_ack <= 1'b0;
      o_line_err <= 1'b0;
    end
    else if (i_line_req && !o_line_ack && wait_cnt == i_delay)
    begin
      wait_cnt <= 4'h0;
      o_line_ack <= 1'b1;
      o_line_err <= i_err_en && (i_line_index == i_err_index);
    end
    else
    begin
      wait_cnt <= (i_line_req && !o_line_ack) ? wait_cnt + 4'h1 : 4'h0;
      o_line_ack <= 1'b0;
      o_line_err <= ~o_line_err;
    end
  end
endmodule // line_ram_model

// ### testbench.sv
// Self-checking bench for the L2 op engine over its register bus
`timescale 1ns/1ns
`include "l2_op_params.svh"
module testbench;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [11:0] i_address = 12'h000;
  logic [31:0] i_writedata = 32'h0;
  logic inhibit = 1'b0;
  logic st_en = 1'b0;
  logic st_done = 1'b0;
  logic err_en = 1'b0;
  logic [41:0] err_idx = 42'h0;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic line_req;
  logic [41:0] line_index;
  logic [2:0] line_kind;
  logic line_ack;
  logic line_err;
  logic hold;
  logic [31:0] rd;
  logic [2:0] seen_kind;
  logic [41:0] idx_q[$];
  logic [2:0] kinds[6] = '{3'h1, 3'h2, 3'h0, 3'h4, 3'h5, 3'h6};
  int bad_count = 0;
  int total_checks = 0;
  int n;

  l2_op_engine #(.NUM_LINES(42'h8)) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_byteenable(4'hf), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_auto_init_inhibit_in(inhibit), .i_self_test_enable(st_en),
    .i_self_test_done(st_done), .o_line_req(line_req),
    .o_line_index(line_index), .o_line_kind(line_kind),
    .i_line_ack(line_ack), .i_line_err(line_err),
    .o_coherent_hold(hold));

  line_ram_model ram (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_line_req(line_req),
    .i_line_index(line_index), .i_delay(4'h2), .i_err_en(err_en),
    .i_err_index(err_idx), .o_line_ack(line_ack), .o_line_err(line_err));

  // 100 MHz clock
  always #5 i_mclk = ~i_mclk;

  // Log each completed line and its kind
  always @(posedge i_mclk)
  begin
    if (line_req && line_ack)
    begin
      idx_q.push_back(line_index);
      seen_kind = line_kind;
    end
  end

  task check(input string name, input logic [41:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task timeout;
    bad_count++;
    print_verdict();
  endtask

  // One Avalon access; held until waitrequest is sampled low
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_mclk);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= !wr;
    do
    begin
      @(posedge i_mclk);
      k++;
      if (k > 50)
        timeout();
    end while (o_waitrequest);
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask

  task do_reset(input logic inh, input logic ste);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    inhibit <= inh;
    st_en <= ste;
    st_done <= 1'b0;
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    idx_q.delete();
  endtask

  // Poll a register bit until it reads the wanted level
  task poll(input logic [11:0] a, input int b, input logic v);
    int k;
    k = 0;
    do
    begin
      bus(1'b0, a, 32'h0);
      k++;
      if (k > 100)
        timeout();
    end while (rd[b] !== v);
  endtask

  task run_op(input logic [2:0] k, input int cnt, input logic [41:0] first,
              input logic [2:0] outc);
    idx_q.delete();
    bus(1'b0, `OFS_OP_CTRL_LO, 32'h0);
    check("idle before start", 42'(rd[`POS_OP_RUNNING]), 42'h0);
    // Kind is selected first; the start acts on the stored kind
    bus(1'b1, `OFS_OP_CTRL_LO, {27'h0, k, 2'h0});
    bus(1'b1, `OFS_OP_CTRL_LO, {27'h0, k, `CMD_START});
    if (cnt > 0)
    begin
      bus(1'b0, `OFS_OP_CTRL_LO, 32'h0);
      check("busy fields", 42'(rd[8:5]), 42'h1);
      check("no hold manual", 42'(hold), 42'h0);
      // A second start with kind 6 must change nothing
      bus(1'b1, `OFS_OP_CTRL_LO, {27'h0, 3'h6, `CMD_START});
    end
    poll(`OFS_OP_CTRL_LO, `POS_OP_RUNNING, 1'b0);
    check("outcome", 42'(rd[8:6]), 42'(outc));
    check("kind kept", 42'(rd[4:2]), 42'(k));
    check("line count", 42'(idx_q.size()), 42'(cnt));
    if (cnt > 0)
    begin
      check("first line", idx_q[0], first);
      check("last line", idx_q[cnt-1], first + 42'(cnt - 1));
      check("line kind", 42'(seen_kind), 42'(k));
    end
  endtask

  // Main sequence
  initial
  begin
    do_reset(1'b0, 1'b1);
    repeat (40) @(posedge i_mclk);
    check("wait self-test", 42'(idx_q.size()), 42'h0);
    check("hold in auto init", 42'(hold), 42'h1);
    // Still waiting for self-test: nothing is running yet
    bus(1'b0, `OFS_OP_CTRL_LO, 32'h0);
    check("auto waiting", 42'(rd[`POS_OP_RUNNING]), 42'h0);
    st_done <= 1'b1;
    poll(`OFS_RAM_CFG_LO, `POS_HW_INIT_DONE, 1'b1);
    check("auto lines", 42'(idx_q.size()), 42'h8);
    check("auto kind", 42'(seen_kind), 42'h1);
    check("hold released", 42'(hold), 42'h0);
    // Auto init must not start before the programmed delay
    do_reset(1'b0, 1'b0);
    n = 0;
    while (!line_req)
    begin
      @(posedge i_mclk);
      n++;
      if (n > 200)
        timeout();
    end
    check("delay", 42'(n >= int'(`RST_INIT_DELAY)), 42'h1);
    poll(`OFS_RAM_CFG_LO, `POS_HW_INIT_DONE, 1'b1);
    bus(1'b0, `OFS_CLUSTER_CFG, 32'h0);
    check("cluster cfg", 42'(rd), 42'h0100_0010);
    bus(1'b1, `OFS_RAM_CFG_LO, 32'h0);
    bus(1'b0, `OFS_RAM_CFG_LO, 32'h0);
    check("done read-only", 42'(rd[16]), 42'h1);
    bus(1'b0, `OFS_RAM_CFG_HI, 32'h0);
    check("ram cfg hi", 42'(rd), 42'h0);
    bus(1'b0, 12'h100, 32'h0);
    check("unmapped", 42'(rd), 42'h0);
    bus(1'b0, `OFS_OP_CTRL_LO, 32'h0);
    check("ctrl idle", 42'(rd & 32'h8000_01e3), 42'h8000_0040);
    // Nothing beyond the auto init lines was launched by hardware
    check("no self launch", 42'(idx_q.size()), 42'h8);
    // Enable bit cleared before the delay ends
    do_reset(1'b0, 1'b0);
    bus(1'b1, `OFS_CLUSTER_CFG, 32'h0000_0010);
    repeat (60) @(posedge i_mclk);
    check("no auto lines", 42'(idx_q.size()), 42'h0);
    check("no hold", 42'(hold), 42'h0);
    // Strap high: manual path only
    do_reset(1'b1, 1'b0);
    repeat (60) @(posedge i_mclk);
    check("inhibit lines", 42'(idx_q.size()), 42'h0);
    check("inhibit hold", 42'(hold), 42'h0);
    bus(1'b0, `OFS_RAM_CFG_LO, 32'h0);
    check("inhibit done", 42'(rd[16]), 42'h0);
    bus(1'b1, `OFS_RANGE_LO, 32'h0000_00c0);
    // Count of 3 stays within the 8-line cache
    bus(1'b1, `OFS_RANGE_HI, 32'h0003_0000);
    // Whole-cache kinds walk 8 lines, bursts walk lines 3..5
    foreach (kinds[i])
    begin
      if (kinds[i] < 3'h4)
        run_op(kinds[i], 8, 42'h0, 3'h1);
      else
        run_op(kinds[i], 3, 42'h3, 3'h1);
    end
    // Faulty line mid-burst, then an invalid kind
    err_en <= 1'b1;
    err_idx <= 42'h4;
    run_op(3'h4, 3, 42'h3, 3'h2);
    err_en <= 1'b0;
    run_op(3'h3, 0, 42'h0, 3'h3);
    print_verdict();
  end
endmodule // testbench
